// *** analog_conv_model.sv ***
// Behavioural model of the converters behind the controller.
`timescale 1ns/100ps
module analog_conv_model (
    // Clock and reset.
    input wire logic clk,
    input wire logic nrst,
    // Requests from the controller.
    input wire logic ad_start,
    input wire logic ad_channel,
    input wire logic da_load,
    // Samples per channel, answer delay and silence.
    input wire logic signed [15:0] meas0,
    input wire logic signed [15:0] meas1,
    input wire logic [3:0] lag,
    input wire logic mute,
    // Answers.
    output logic ad_valid,
    output logic signed [15:0] ad_meas,
    output logic da_accept
);
    logic [3:0] ad_wait;
    logic [3:0] da_wait;
    logic ad_due;
    logic da_due;

    // Answer on the request edge for lag zero, else lag cycles later.
    assign ad_due = !mute && (ad_start ? lag == 4'h0 : ad_wait == 4'h1);
    assign da_due = !mute && (da_load ? lag == 4'h0 : da_wait == 4'h1);

    // The sample bus toggles outside valid cycles so stale data never matches.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ad_wait <= 4'h0;
            da_wait <= 4'h0;
            ad_valid <= 1'b0;
            da_accept <= 1'b0;
            ad_meas <= 16'h5A5A;
        end else begin
            ad_wait <= ad_start ? lag : ad_wait - 4'(ad_wait != 4'h0);
            da_wait <= da_load ? lag : da_wait - 4'(da_wait != 4'h0);
            ad_valid <= ad_due;
            da_accept <= da_due;
            ad_meas <= ad_due ? (ad_channel ? meas1 : meas0) : ~ad_meas;
        end
    end
endmodule

// *** analog_io_access.sv ***
// Wishbone controller that runs read and write requests against the analog I/O module.
`timescale 1ns/100ps
`include "analog_io_defs.svh"

module analog_io_access #(
    parameter int SLOT_COUNT = 3,
    parameter int ANSWER_LIMIT = `ANSWER_CYCLES
) (
    // Clock and synchronous active-low reset.
    input wire logic CLK,
    input wire logic NRST,
    // Classic Wishbone slave.
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // Module presence per slot, bit zero is slot one.
    input wire logic [SLOT_COUNT-1:0] SLOT_PRESENT,
    input wire logic [SLOT_COUNT-1:0] SLOT_IS_AIO,
    // Input converter link.
    output logic AD_START,
    output logic [1:0] AD_SLOT,
    output logic AD_CHANNEL,
    output logic AD_RANGE_VOLTAGE,
    input wire logic AD_VALID,
    input wire logic signed [15:0] AD_MEAS,
    // Output converter link.
    output logic DA_LOAD,
    output logic [1:0] DA_SLOT,
    output logic DA_RANGE_VOLTAGE,
    output logic [15:0] DA_LEVEL,
    input wire logic DA_ACCEPT,
    // Result flags.
    output logic DONE,
    output logic [7:0] STAT
);

    // Refuse slot counts the slot field and the error check cannot address.
    if (SLOT_COUNT < 1 || SLOT_COUNT > 3) begin : bad_slot_count
        $error("SLOT_COUNT must lie between 1 and 3.");
    end
    if (ANSWER_LIMIT < 2 || ANSWER_LIMIT > 65535) begin : bad_answer_limit
        $error("ANSWER_LIMIT must lie between 2 and 65535.");
    end

    // Merges bus write data into a register under the byte selects.
    function automatic logic [31:0] merge_sel(input logic [31:0] old_val,
                                              input logic [31:0] new_val,
                                              input logic [3:0] sel);
        logic [31:0] result;
        result = old_val;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                result[i*8 +: 8] = new_val[i*8 +: 8];
            end
        end
        return result;
    endfunction

    // Picks the bit of a per-slot vector for a one-based slot number.
    function automatic logic slot_bit(input logic [SLOT_COUNT-1:0] vec,
                                      input logic [7:0] slot);
        logic found;
        found = 1'b0;
        for (int i = 0; i < SLOT_COUNT; i++) begin
            if (slot == 8'(i + 1)) begin
                found = vec[i];
            end
        end
        return found;
    endfunction

    // Software-written registers.
    logic [31:0] ctrl;
    logic [15:0] wdata;
    logic request_prev;

    // Latched command of the running execution.
    analog_io_pkg::op_t cmd_op;
    logic [7:0] cmd_slot;
    logic [7:0] cmd_channel;
    analog_io_pkg::range_t cmd_range;
    logic [15:0] cmd_code;

    // Sequencer and results.
    analog_io_pkg::state_t state;
    logic [15:0] wait_count;
    logic stopped;
    logic signed [15:0] read_data;
    logic [15:0] out_level;
    logic out_range;

    // Bus decode. A request is taken while ack is low; a write lands at the edge
    // where the master samples ack high, so master and slave agree on the moment
    // a control write becomes visible to the sequencer.
    wire bus_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
    wire bus_write = WB_CYC_I & WB_STB_I & WB_WE_I & WB_ACK_O;
    wire hit_ctrl = WB_ADR_I == `OFS_CTRL;
    wire hit_wdata = WB_ADR_I == `OFS_WDATA;
    wire hit_status = WB_ADR_I == `OFS_STATUS;
    wire hit_rdata = WB_ADR_I == `OFS_RDATA;
    wire hit_output = WB_ADR_I == `OFS_OUTPUT;
    wire [31:0] ctrl_written = merge_sel(ctrl, WB_DAT_I, WB_SEL_I) & `CTRL_WRITABLE;
    wire [31:0] wdata_written = merge_sel({16'h0000, wdata}, WB_DAT_I, WB_SEL_I);

    // Busy covers the check and wait cycles of an execution.
    wire busy = state != analog_io_pkg::ST_IDLE;

    // Read data mux; unmapped addresses read as zero and are still acknowledged.
    wire [31:0] status_word = {16'h0000, STAT, 5'h00, stopped, busy, DONE};
    wire [31:0] next_rd_word = hit_ctrl ? ctrl :
        hit_wdata ? {16'h0000, wdata} :
        hit_status ? status_word :
        hit_rdata ? {{16{read_data[15]}}, read_data} :
        hit_output ? {15'h0000, out_range, out_level} : 32'h0000_0000;

    // Request field decode.
    wire request_level = ctrl[`CTRL_REQ_BIT];
    wire request_rise = request_level & ~request_prev;
    wire [1:0] req_op_bits = ctrl[`CTRL_OP_HI:`CTRL_OP_LO];
    wire is_read = ~cmd_op[1];

    // Current-only operations ignore the range select and force current.
    wire range_bit = ctrl[`CTRL_RANGE_BIT];
    wire current_only = req_op_bits[0];
    analog_io_pkg::range_t req_range;
    assign req_range = (current_only | ~range_bit) ? analog_io_pkg::RANGE_CURRENT :
        analog_io_pkg::RANGE_VOLTAGE;

    // Error check of the latched command, first failing test wins.
    // Checking slot and channel here costs a cycle but keeps the bus path short.
    wire slot_bad = cmd_slot < `SLOT_MIN || cmd_slot > `SLOT_MAX ||
        cmd_slot > 8'(SLOT_COUNT);
    wire slot_empty = ~slot_bit(SLOT_PRESENT, cmd_slot);
    wire slot_wrong = ~slot_bit(SLOT_IS_AIO, cmd_slot);
    wire channel_bad = is_read & (cmd_channel > `CH_MAX);
    wire code_bad = ~is_read & (cmd_code > `DA_CODE_MAX);
    wire [7:0] check_err = slot_bad ? `ERR_SLOT :
        slot_empty ? `ERR_EMPTY :
        slot_wrong ? `ERR_KIND :
        channel_bad ? `ERR_CHANNEL :
        code_bad ? `ERR_DATA : `ERR_NONE;
    wire answer_late = wait_count == 16'(ANSWER_LIMIT - 1);

    // Launch strobes: only a command that passed every check reaches a converter.
    // A refused command leaves the converter fields as the last good run set them.
    wire launch_read = state == analog_io_pkg::ST_CHECK && check_err == `ERR_NONE && is_read;
    wire launch_write = state == analog_io_pkg::ST_CHECK && check_err == `ERR_NONE && !is_read;

    // Scaling of measurements and codes.
    logic signed [15:0] scaled_code;
    logic [15:0] scaled_level;

    analog_scale scaler (
        .meas(AD_MEAS),
        .code_in(cmd_code),
        .code_out(scaled_code),
        .level_out(scaled_level)
    );

    // Bus answer: registered ack after one wait cycle, ack drops in the cycle after it was given.
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h0000_0000;
        end else begin
            WB_ACK_O <= bus_req;
            WB_DAT_O <= bus_req ? next_rd_word : 32'h0000_0000;
        end
    end

    // Control and write-data registers, taken on the acknowledged cycle.
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            ctrl <= `CTRL_RESET;
            wdata <= `WDATA_RESET;
        end else begin
            if (bus_write & hit_ctrl) begin
                ctrl <= ctrl_written;
            end
            if (bus_write & hit_wdata) begin
                wdata <= wdata_written[15:0];
            end
        end
    end

    // Edge memory of the request bit; it follows the level in every state,
    // so a request held high never starts a second execution.
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            request_prev <= 1'b0;
        end else begin
            request_prev <= request_level;
        end
    end

    // Sequencer: latch, check, run the converter access, report.
    // Every failure returns to idle with the stopped flag set; the next rise restarts.
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            state <= analog_io_pkg::ST_IDLE;
            cmd_op <= analog_io_pkg::OP_READ_ANY;
            cmd_slot <= 8'h00;
            cmd_channel <= 8'h00;
            cmd_range <= analog_io_pkg::RANGE_CURRENT;
            cmd_code <= 16'h0000;
            wait_count <= 16'h0000;
            stopped <= 1'b0;
            DONE <= 1'b0;
            STAT <= `ERR_NONE;
        end else begin
            case (state)
                analog_io_pkg::ST_IDLE: begin
                    // A rise while busy is not stored; software sees busy and retries.
                    if (request_rise) begin
                        cmd_op <= analog_io_pkg::op_t'(req_op_bits);
                        cmd_slot <= ctrl[`CTRL_SLOT_HI:`CTRL_SLOT_LO];
                        cmd_channel <= ctrl[`CTRL_CH_HI:`CTRL_CH_LO];
                        cmd_range <= req_range;
                        cmd_code <= wdata;
                        DONE <= 1'b0;
                        STAT <= `ERR_NONE;
                        stopped <= 1'b0;
                        state <= analog_io_pkg::ST_CHECK;
                    end
                end
                analog_io_pkg::ST_CHECK: begin
                    wait_count <= 16'h0000;
                    if (check_err != `ERR_NONE) begin
                        STAT <= check_err;
                        DONE <= 1'b0;
                        stopped <= 1'b1;
                        state <= analog_io_pkg::ST_IDLE;
                    end else if (is_read) begin
                        state <= analog_io_pkg::ST_READ;
                    end else begin
                        state <= analog_io_pkg::ST_WRITE;
                    end
                end
                analog_io_pkg::ST_READ: begin
                    // An answer in the last allowed cycle still counts as clean.
                    wait_count <= wait_count + 16'h0001;
                    if (AD_VALID) begin
                        DONE <= 1'b1;
                        state <= analog_io_pkg::ST_IDLE;
                    end else if (answer_late) begin
                        STAT <= `ERR_TIMEOUT;
                        DONE <= 1'b0;
                        stopped <= 1'b1;
                        state <= analog_io_pkg::ST_IDLE;
                    end
                end
                analog_io_pkg::ST_WRITE: begin
                    // An accept in the last allowed cycle still counts as clean.
                    wait_count <= wait_count + 16'h0001;
                    if (DA_ACCEPT) begin
                        DONE <= 1'b1;
                        state <= analog_io_pkg::ST_IDLE;
                    end else if (answer_late) begin
                        STAT <= `ERR_TIMEOUT;
                        DONE <= 1'b0;
                        stopped <= 1'b1;
                        state <= analog_io_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state <= analog_io_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Read result: only a converter answer that arrives during the read wait is kept.
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            read_data <= 16'sh0000;
        end else if (state == analog_io_pkg::ST_READ && AD_VALID) begin
            read_data <= scaled_code;
        end
    end

    // Input converter request: a one-cycle start with slot, channel and range held.
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            AD_START <= 1'b0;
            AD_SLOT <= 2'h0;
            AD_CHANNEL <= 1'b0;
            AD_RANGE_VOLTAGE <= 1'b0;
        end else begin
            AD_START <= launch_read;
            // Fields move only with a launch, so they stay put across refused runs.
            if (launch_read) begin
                AD_SLOT <= cmd_slot[1:0];
                AD_CHANNEL <= cmd_channel[0];
                AD_RANGE_VOLTAGE <= cmd_range == analog_io_pkg::RANGE_VOLTAGE;
            end
        end
    end

    // Output converter load: the single output channel needs no channel field.
    // The held level keeps driving until the next write that passes the checks replaces it, even one that then times out.
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            DA_LOAD <= 1'b0;
            DA_SLOT <= 2'h0;
            DA_RANGE_VOLTAGE <= 1'b0;
            DA_LEVEL <= 16'h0000;
            out_level <= 16'h0000;
            out_range <= 1'b0;
        end else begin
            DA_LOAD <= launch_write;
            if (launch_write) begin
                DA_SLOT <= cmd_slot[1:0];
                DA_RANGE_VOLTAGE <= cmd_range == analog_io_pkg::RANGE_VOLTAGE;
                DA_LEVEL <= scaled_level;
                out_level <= scaled_level;
                out_range <= cmd_range == analog_io_pkg::RANGE_VOLTAGE;
            end
        end
    end

endmodule

// *** analog_io_access_blocks_bench.sv ***
// Self-checking bench for the analog access controller.
`timescale 1ns/100ps
`include "analog_io_defs.svh"
module analog_io_access_blocks_bench;
    logic clk, nrst, cyc, stb, we, ack, mute;
    logic [7:0] adr, stat;
    logic [31:0] wdat, dat_o, rd;
    logic ad_start, ad_ch, ad_rv, ad_valid, da_load, da_rv, da_accept, done;
    logic [1:0] ad_slot, da_slot;
    logic signed [15:0] ad_meas, meas0, meas1;
    logic [15:0] da_level;
    logic [3:0] lag;
    int err_count = 0, checks = 0, starts = 0, n;
    // Clean runs: op, range, channel, sample or code, expected result, range out.
    int t_op[8] = '{0, 0, 1, 0, 0, 2, 3, 2};
    int t_rg[8] = '{1, 0, 1, 1, 1, 1, 1, 0};
    int t_ch[8] = '{0, 1, 0, 1, 0, 0, 0, 0};
    int t_in[8] = '{20000, 10004, 9, -300, 9, 4000, 2000, 1};
    int t_ex[8] = '{4000, 2000, 1, -48, 1, 20000, 10000, 5};
    int t_rv[8] = '{1, 0, 0, 1, 1, 1, 0, 0};
    // Failing runs: slot, op, channel, code, error number.
    int e_sl[7] = '{0, 4, 2, 3, 1, 1, 1};
    int e_op[7] = '{0, 2, 0, 3, 0, 2, 1};
    int e_ch[7] = '{0, 0, 0, 0, 2, 0, 0};
    int e_cd[7] = '{5, 5, 5, 5, 5, 4001, 5};
    int e_ex[7] = '{3, 3, 4, 5, 6, 7, 8};

    analog_io_access #(.SLOT_COUNT(3), .ANSWER_LIMIT(8)) dut (
        .CLK(clk), .NRST(nrst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(dat_o),
        .WB_ACK_O(ack), .SLOT_PRESENT(3'h5), .SLOT_IS_AIO(3'h3),
        .AD_START(ad_start), .AD_SLOT(ad_slot), .AD_CHANNEL(ad_ch),
        .AD_RANGE_VOLTAGE(ad_rv), .AD_VALID(ad_valid), .AD_MEAS(ad_meas),
        .DA_LOAD(da_load), .DA_SLOT(da_slot), .DA_RANGE_VOLTAGE(da_rv),
        .DA_LEVEL(da_level), .DA_ACCEPT(da_accept), .DONE(done), .STAT(stat));

    analog_conv_model conv (
        .clk(clk), .nrst(nrst), .ad_start(ad_start), .ad_channel(ad_ch),
        .da_load(da_load), .meas0(meas0), .meas1(meas1), .lag(lag), .mute(mute),
        .ad_valid(ad_valid), .ad_meas(ad_meas), .da_accept(da_accept));

    // Free-running clock, 4 ns period.
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Count sample requests so repeated launches are visible.
    always @(posedge clk) if (ad_start === 1'b1) starts++;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // One classic cycle; request held until ack is sampled high.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        forever begin
            @(posedge clk);
            if (ack === 1'b1) break;
        end
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    // Clear then set the request bit, then poll until the run is over.
    task automatic run(input int op, rg, sl, ch);
        logic [31:0] c;
        c = {8'h00, 8'(ch), 8'(sl), 4'h0, 1'(rg), 2'(op), 1'b0};
        wb(1'b1, `OFS_CTRL, c);
        wb(1'b1, `OFS_CTRL, c | 32'h1);
        repeat (40) begin
            wb(1'b0, `OFS_STATUS, 32'h0);
            if (rd[`STATUS_BUSY_BIT] === 1'b0) break;
        end
        check(32'(rd[`STATUS_BUSY_BIT]), 32'h0);
    endtask

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // A hang is cut off well past the expected run length.
    initial begin
        repeat (8000) @(posedge clk);
        err_count++;
        tally_and_finish();
    end

    initial begin
        {nrst, cyc, stb, we, mute} = 5'h00;
        {adr, wdat, lag, meas0, meas1} = '0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        wb(1'b0, `OFS_CTRL, 32'h0);
        check(rd, 32'h0);
        wb(1'b0, `OFS_WDATA, 32'h0);
        check(rd, 32'h0);
        wb(1'b1, 8'h14, 32'hFFFF_FFFF);
        wb(1'b0, 8'h14, 32'h0);
        check(rd, 32'h0);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            lag <= (i % 2 == 0) ? 4'h0 : 4'h5;
            meas0 <= (t_ch[i] == 0) ? 16'(t_in[i]) : 16'sh0FA0;
            meas1 <= (t_ch[i] == 1) ? 16'(t_in[i]) : 16'sh0FA0;
            if (t_op[i] > 1) wb(1'b1, `OFS_WDATA, 32'(t_in[i]));
            run(t_op[i], t_rg[i], 1, t_ch[i]);
            check(rd & 32'h0000_FF07, 32'h1);
            check(32'({stat, done}), 32'h1);
            if (t_op[i] < 2) begin
                wb(1'b0, `OFS_RDATA, 32'h0);
                check(rd, 32'(t_ex[i]));
                check(32'({ad_slot, ad_ch, ad_rv}), 32'(4 + t_ch[i] * 2 + t_rv[i]));
            end else begin
                wb(1'b0, `OFS_OUTPUT, 32'h0);
                check(rd, 32'(t_rv[i] * 65536 + t_ex[i]));
                check(32'({da_slot, da_rv, da_level}),
                      32'(131072 + t_rv[i] * 65536 + t_ex[i]));
            end
        end
        // A held request must not relaunch, and done must hold.
        run(0, 1, 1, 0);
        n = starts;
        wb(1'b1, `OFS_CTRL, 32'h0000_0109);
        repeat (20) @(posedge clk);
        check(32'(starts), 32'(n));
        check(32'(done), 32'h1);
        for (int i = 0; i < 7; i++) begin
            @(posedge clk);
            mute <= (e_ex[i] == 8);
            wb(1'b1, `OFS_WDATA, 32'(e_cd[i]));
            run(e_op[i], 0, e_sl[i], e_ch[i]);
            check(rd & 32'h0000_FF01, 32'(e_ex[i] * 256));
            check(32'({stat, done}), 32'(e_ex[i] * 2));
        end
        tally_and_finish();
    end
endmodule

// *** analog_io_checker.sv ***
// Port assertions for the analog access controller.
`timescale 1ns/100ps
module analog_io_checker #(
    parameter int SLOT_COUNT = 3,
    parameter int ANSWER_LIMIT = 1000
) (
    // Clock and reset.
    input wire logic CLK,
    input wire logic NRST,
    // Bus handshake.
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_ACK_O,
    // Converter links.
    input wire logic AD_START,
    input wire logic [1:0] AD_SLOT,
    input wire logic AD_CHANNEL,
    input wire logic AD_RANGE_VOLTAGE,
    input wire logic AD_VALID,
    input wire logic DA_LOAD,
    input wire logic [15:0] DA_LEVEL,
    input wire logic DA_ACCEPT,
    // Result flags.
    input wire logic DONE,
    input wire logic [7:0] STAT
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);

    // A sample asked for and answered on the next edge.
    sequence s_quick_read;
        AD_START ##1 AD_VALID;
    endsequence
    // Two quiet cycles on the sample request.
    sequence s_quiet;
        !AD_START ##1 !AD_START;
    endsequence

    chk_ack_single: assert property ( // bus
        WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O ##1 !WB_ACK_O)
        else $error("Bus ack is not a single pulse.");
    chk_start_once: assert property (AD_START |=> !AD_START)
        else $error("Sample request longer than one cycle.");
    chk_load_once: assert property (DA_LOAD |=> !DA_LOAD)
        else $error("Output load longer than one cycle.");
    chk_error_no_done: assert property (STAT != 8'h00 |-> !DONE)
        else $error("Done set together with an error number.");
    chk_launch_clean: assert property (
        $rose(AD_START) || $rose(DA_LOAD) |-> !DONE && STAT == 8'h00)
        else $error("Done or error left over from the previous run.");
    chk_fields_hold: assert property (
        s_quiet |-> $stable({AD_SLOT, AD_CHANNEL, AD_RANGE_VOLTAGE}))
        else $error("Sample request fields moved between requests.");
    chk_level_scaled: assert property (
        DA_LOAD |-> DA_LEVEL <= 16'h4E20 && DA_LEVEL % 16'h0005 == 16'h0000)
        else $error("Output level off the five-unit scale.");
    chk_quick_done: assert property (s_quick_read |=> DONE && STAT == 8'h00)
        else $error("Answered read did not finish clean.");
    chk_done_cause: assert property (
        $rose(DONE) |-> $past(AD_VALID) || $past(DA_ACCEPT))
        else $error("Done rose without a converter answer.");
endmodule

bind analog_io_access analog_io_checker #(
    .SLOT_COUNT(SLOT_COUNT),
    .ANSWER_LIMIT(ANSWER_LIMIT)
) chk (
    .CLK(CLK), .NRST(NRST),
    .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O),
    .AD_START(AD_START), .AD_SLOT(AD_SLOT), .AD_CHANNEL(AD_CHANNEL),
    .AD_RANGE_VOLTAGE(AD_RANGE_VOLTAGE), .AD_VALID(AD_VALID),
    .DA_LOAD(DA_LOAD), .DA_LEVEL(DA_LEVEL), .DA_ACCEPT(DA_ACCEPT),
    .DONE(DONE), .STAT(STAT)
);

// *** analog_io_defs.svh ***
// Register offsets, field positions, reset values, error numbers and timing counts.
`ifndef ANALOG_IO_DEFS_SVH
`define ANALOG_IO_DEFS_SVH

// Register byte offsets on the Wishbone bus.
`define OFS_CTRL 8'h00
`define OFS_WDATA 8'h04
`define OFS_STATUS 8'h08
`define OFS_RDATA 8'h0C
`define OFS_OUTPUT 8'h10

// Control register fields.
`define CTRL_REQ_BIT 0
`define CTRL_OP_LO 1
`define CTRL_OP_HI 2
`define CTRL_RANGE_BIT 3
`define CTRL_SLOT_LO 8
`define CTRL_SLOT_HI 15
`define CTRL_CH_LO 16
`define CTRL_CH_HI 23
`define CTRL_WRITABLE 32'h00FF_FF0F

// Status register fields.
`define STATUS_DONE_BIT 0
`define STATUS_BUSY_BIT 1
`define STATUS_STOP_BIT 2
`define STATUS_STAT_LO 8
`define STATUS_STAT_HI 15

// Output register fields.
`define OUTPUT_RANGE_BIT 16

// Reset values.
`define CTRL_RESET 32'h0000_0000
`define WDATA_RESET 16'h0000

// Error numbers placed on the status output.
`define ERR_NONE 8'h00
`define ERR_SLOT 8'h03
`define ERR_EMPTY 8'h04
`define ERR_KIND 8'h05
`define ERR_CHANNEL 8'h06
`define ERR_DATA 8'h07
`define ERR_TIMEOUT 8'h08

// Request limits and code range.
`define SLOT_MIN 8'h01
`define SLOT_MAX 8'h03
`define CH_MAX 8'h01
`define DA_CODE_MAX 16'h0FA0
`define AD_CODE_MIN 16'hFFD0
`define AD_CODE_MAX 16'h0FCF
`define MEAS_PER_COUNT 16'h0005

// Longest wait for the converter's answer.
`define CLK_PERIOD_NS 4
`define ANSWER_TIME_NS 4000
`define ANSWER_CYCLES (`ANSWER_TIME_NS / `CLK_PERIOD_NS)

`endif

// *** analog_io_pkg.sv ***
// Types used by the analog access controller.
package analog_io_pkg;

    // The four operations selected by the control register.
    typedef enum logic [1:0] {
        OP_READ_ANY = 2'b00,
        OP_READ_CURRENT = 2'b01,
        OP_WRITE_ANY = 2'b10,
        OP_WRITE_CURRENT = 2'b11
    } op_t;

    // Sequencer states.
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_CHECK = 3'b001,
        ST_READ = 3'b010,
        ST_WRITE = 3'b011
    } state_t;

    // Range select: zero is current, one is voltage.
    typedef enum logic {
        RANGE_CURRENT = 1'b0,
        RANGE_VOLTAGE = 1'b1
    } range_t;

endpackage

// *** analog_scale.sv ***
// Converts converter measurements to codes and codes to output levels.
`timescale 1ns/100ps
`include "analog_io_defs.svh"

module analog_scale (
    // Measurement from the input converter, half-millivolts or microamps.
    input wire logic signed [15:0] meas,
    // Output code from software.
    input wire logic [15:0] code_in,
    // Signed input code and output level in converter units.
    output logic signed [15:0] code_out,
    output logic [15:0] level_out
);

    logic [15:0] magnitude;
    logic [15:0] quotient;
    logic signed [15:0] signed_code;
    logic [31:0] product;

    // Both ranges give five measurement units per count, so one divider serves them.
    // Dividing the magnitude drops the fraction toward zero for either sign.
    assign magnitude = meas[15] ? 16'(-meas) : 16'(meas);
    assign quotient = magnitude / `MEAS_PER_COUNT;
    assign signed_code = meas[15] ? 16'(-quotient) : 16'(quotient);

    // Clamp to the code range the data output can carry.
    assign code_out = (signed_code < $signed(`AD_CODE_MIN)) ? $signed(`AD_CODE_MIN) :
        (signed_code > $signed(`AD_CODE_MAX)) ? $signed(`AD_CODE_MAX) : signed_code;

    // Output level is linear in the code: zero gives zero, full code gives full scale.
    assign product = code_in * `MEAS_PER_COUNT;
    assign level_out = product[15:0];

endmodule
